// ### verilog/sfb_core.sv
// Operation
// - transfer opcodes 53H/55H select buffer one/two
// - standard mode page index at address bits 19:9
// - binary mode page index at bits 18:8
// - operation starts on chip-select rise, busy
// - compare opcodes 60H/61H, same address format
// - compare result written into status bit six
// - rewrite opcodes 58H/59H, same address format
// - rewrite copies page then programs it back
// - status read accepted even while busy, except in sleep entry and sleep
// - status shifted msb first, eight clocks
// - status repeats with fresh contents each byte
// - bit seven high idle, low busy
// - all self-timed operations hold busy
// - bit one reports sector protection
// - bit zero reports binary page size
// - bits five to two fixed density code
// - B9H then chip-select rise enters sleep
// - sleep ignores all but wake command
// - ABH then chip-select rise resumes standby
// - reset leaves device in standby
`include "sfb_cfg.svh"
module sfb_core #(
  parameter int COPY_CYC = (`SFB_COPY_NS) / (`SFB_CLK_NS),
  parameter int MATCH_CYC = (`SFB_MATCH_NS) / (`SFB_CLK_NS),
  parameter int REWRITE_CYC = (`SFB_REWRITE_NS) / (`SFB_CLK_NS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  input wire logic binary_page,
  input wire logic protect_on,
  input wire logic page_match,
  output logic busy,
  output logic asleep,
  output logic page_op_start,
  output logic [10:0] page_index,
  output logic buf_two_sel,
  output logic page_op_is_cmp
);
  sfb_pkg::sfb_state_t st_reg;
  sfb_pkg::sfb_state_t st_next;
  sfb_pkg::sfb_status_t stat;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_low;
  logic [7:0] op;
  logic [7:0] op_short;
  logic start_op;

  assign sck_rise = st_reg.sck_sync[1] & ~st_reg.sck_sync[2];
  assign sck_fall = ~st_reg.sck_sync[1] & st_reg.sck_sync[2];
  assign cs_low = ~st_reg.cs_sync[1];
  assign cs_rise = st_reg.cs_sync[1] & ~st_reg.cs_prev;
  assign op = st_reg.shift[31:24];
  // one-byte commands leave their opcode in the low byte, never in the top one
  assign op_short = st_reg.shift[7:0];

  always_comb
  begin
    // rebuilt every cycle, so each repeated status byte carries fresh contents
    stat.ready = (st_reg.mode == sfb_pkg::SFB_IDLE);
    stat.mismatch = st_reg.mismatch;
    stat.density = `SFB_DENSITY;
    stat.protect = protect_on;
    stat.binary_page = binary_page;
  end

  always_comb
  begin
    st_next = st_reg;
    start_op = 1'b0;
    // pins cross through two flops; the link clock must stay at or below mclk/8
    st_next.sck_sync = {st_reg.sck_sync[1:0], sclk};
    st_next.cs_sync = {st_reg.cs_sync[0], cs_n};
    st_next.si_sync = {st_reg.si_sync[0], si};
    st_next.cs_prev = st_reg.cs_sync[1];
    if (!cs_low)
    begin
      st_next.bit_cnt = 6'h00;
      st_next.stat_mode = 1'b0;
      st_next.so_oe = 1'b0;
    end
    else if (sck_rise && !st_reg.stat_mode)
    begin
      // the shifter runs on past 32 bits while the count holds at 32, so 32 or more bits start a page op on the last 32
      st_next.shift = {st_reg.shift[30:0], st_reg.si_sync[1]};
      if (st_reg.bit_cnt != `SFB_CMD_BITS)
        st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
      // status read is honoured in any mode but sleep and sleep entry
      if (st_reg.bit_cnt == `SFB_OP_BITS - 6'h01 &&
          {st_reg.shift[6:0], st_reg.si_sync[1]} == `SFB_OP_STAT &&
          st_reg.mode != sfb_pkg::SFB_SLEEP && st_reg.mode != sfb_pkg::SFB_GO_SLEEP)
      begin
        st_next.stat_mode = 1'b1;
        st_next.out_bit = `SFB_BIT_LAST;
      end
    end
    else if (sck_fall && st_reg.stat_mode)
    begin
      st_next.so_oe = 1'b1;
      st_next.so_o = (st_reg.out_bit == `SFB_BIT_LAST) ? stat.ready : st_reg.out_byte[st_reg.out_bit];
      if (st_reg.out_bit == `SFB_BIT_LAST)
        st_next.out_byte = {stat.ready, stat.mismatch, stat.density, stat.protect, stat.binary_page};
      st_next.out_bit = st_reg.out_bit - 3'h1;
    end
    // one shared down-counter times every self-timed phase
    if (st_reg.timer != 22'h0)
      st_next.timer = st_reg.timer - 22'h1;
    unique case (st_reg.mode)
      sfb_pkg::SFB_IDLE:
        if (cs_rise && st_reg.bit_cnt == `SFB_OP_BITS && op_short == `SFB_OP_SLEEP)
        begin
          st_next.mode = sfb_pkg::SFB_GO_SLEEP;
          st_next.timer = 22'(`SFB_SLEEP_CYC);
        end
        else if (cs_rise && st_reg.bit_cnt == `SFB_CMD_BITS)
        begin
          // page index position depends on page size
          st_next.page = binary_page ? st_reg.shift[18:8] : st_reg.shift[19:9];
          // the transfer pair does not follow the odd-opcode pattern of the others
          st_next.buf_two = (op == `SFB_OP_XFER2) || (op == `SFB_OP_CMP2) || (op == `SFB_OP_RW2);
          st_next.is_cmp = (op == `SFB_OP_CMP1) || (op == `SFB_OP_CMP2);
          if (op == `SFB_OP_XFER1 || op == `SFB_OP_XFER2)
          begin
            st_next.mode = sfb_pkg::SFB_BUSY;
            st_next.timer = 22'(COPY_CYC);
            start_op = 1'b1;
          end
          else if (op == `SFB_OP_CMP1 || op == `SFB_OP_CMP2)
          begin
            st_next.mode = sfb_pkg::SFB_BUSY;
            st_next.timer = 22'(MATCH_CYC);
            start_op = 1'b1;
          end
          else if (op == `SFB_OP_RW1 || op == `SFB_OP_RW2)
          begin
            st_next.mode = sfb_pkg::SFB_RW2;
            st_next.timer = 22'(COPY_CYC);
            start_op = 1'b1;
          end
        end
      sfb_pkg::SFB_BUSY:
        if (st_reg.timer == 22'h0)
        begin
          st_next.mode = sfb_pkg::SFB_IDLE;
          if (st_reg.is_cmp)
            st_next.mismatch = ~page_match;
        end
      sfb_pkg::SFB_RW2:
        if (st_reg.timer == 22'h0)
        begin
          // copy phase done, now program back with erase
          st_next.mode = sfb_pkg::SFB_BUSY;
          st_next.timer = 22'(REWRITE_CYC - COPY_CYC);
        end
      sfb_pkg::SFB_GO_SLEEP:
        if (st_reg.timer == 22'h0)
          st_next.mode = sfb_pkg::SFB_SLEEP;
      // everything but the wake opcode falls through untouched here
      sfb_pkg::SFB_SLEEP:
        if (cs_rise && st_reg.bit_cnt == `SFB_OP_BITS && op_short == `SFB_OP_WAKE)
        begin
          st_next.mode = sfb_pkg::SFB_GO_WAKE;
          st_next.timer = 22'(`SFB_WAKE_CYC);
        end
      sfb_pkg::SFB_GO_WAKE:
        if (st_reg.timer == 22'h0)
          st_next.mode = sfb_pkg::SFB_IDLE;
      default:
        st_next.mode = sfb_pkg::SFB_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // pins reset to their idle levels so no false edge follows release
      st_reg <= '0;
      st_reg.sck_sync <= 3'h0;
      st_reg.cs_sync <= 2'h3;
      st_reg.cs_prev <= 1'b1;
      st_reg.mode <= sfb_pkg::SFB_IDLE;
    end
    else
      st_reg <= st_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      page_op_start <= 1'b0;
    else
      page_op_start <= start_op;
  end

  // enable also follows the synchronised select, so it drops as soon as that rises
  assign so_o = st_reg.so_o;
  assign so_oe = st_reg.so_oe & cs_low;
  assign busy = ~stat.ready;
  assign asleep = (st_reg.mode == sfb_pkg::SFB_SLEEP);
  assign page_index = st_reg.page;
  assign buf_two_sel = st_reg.buf_two;
  assign page_op_is_cmp = st_reg.is_cmp;

  // a page operation is announced only once the machine has gone busy
  busy_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    page_op_start
    |-> busy)
    else $error("page op started without busy");

  // even the shortest page operation lasts far longer than eight cycles
  busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    page_op_start
    |-> busy [*8])
    else $error("busy dropped right after a page op start");

  // sleep reports not ready, so a stray poll can never see idle
  stat_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    asleep
    |-> ##1 (busy))
    else $error("sleep left ready");

  // only the wake opcode may move the machine out of sleep
  sleep_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    asleep && !(cs_rise && st_reg.bit_cnt == `SFB_OP_BITS && op_short == `SFB_OP_WAKE)
    |=> asleep)
    else $error("sleep left without wake command");

  // entry delay over means the device is really asleep
  sleep_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.mode == sfb_pkg::SFB_GO_SLEEP && st_reg.timer == 22'h0
    |=> asleep)
    else $error("sleep not entered after entry time");

  // wake delay over means the device is back in standby
  wake_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.mode == sfb_pkg::SFB_GO_WAKE && st_reg.timer == 22'h0
    |=> !busy)
    else $error("wake stuck");

  // a buffer one transfer starts with the first buffer and no compare
  xfer_buf_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_rise && st_reg.mode == sfb_pkg::SFB_IDLE && st_reg.bit_cnt == `SFB_CMD_BITS && op == `SFB_OP_XFER1
    |=> page_op_start && !buf_two_sel && !page_op_is_cmp)
    else $error("buffer one transfer misdecoded");

  // a buffer two compare starts with the second buffer and compare set
  cmp_buf_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_rise && st_reg.mode == sfb_pkg::SFB_IDLE && st_reg.bit_cnt == `SFB_CMD_BITS && op == `SFB_OP_CMP2
    |=> page_op_start && buf_two_sel && page_op_is_cmp)
    else $error("buffer two compare misdecoded");

  // standard pages take their index from address bits 19 to 9
  page_std_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_rise && st_reg.mode == sfb_pkg::SFB_IDLE && st_reg.bit_cnt == `SFB_CMD_BITS && !binary_page
    |=> page_index == $past(st_reg.shift[19:9]))
    else $error("standard page index misplaced");

  // binary pages take their index from address bits 18 to 8
  page_bin_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_rise && st_reg.mode == sfb_pkg::SFB_IDLE && st_reg.bit_cnt == `SFB_CMD_BITS && binary_page
    |=> page_index == $past(st_reg.shift[18:8]))
    else $error("binary page index misplaced");

  // the compare result is latched as the compare finishes
  cmp_result_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.mode == sfb_pkg::SFB_BUSY && st_reg.timer == 22'h0 && st_reg.is_cmp
    |=> st_reg.mismatch == !$past(page_match))
    else $error("compare result not latched");

  // the copy phase of a rewrite hands over to the program phase, still busy
  rewrite_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.mode == sfb_pkg::SFB_RW2 && st_reg.timer == 22'h0
    |=> st_reg.mode == sfb_pkg::SFB_BUSY && busy)
    else $error("rewrite program phase missing");

  // each status byte opens with the ready bit on the line
  status_msb_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_low && sck_fall && st_reg.stat_mode && st_reg.out_bit == `SFB_BIT_LAST
    |=> so_o == !$past(busy) && st_reg.so_oe)
    else $error("status byte did not open with ready");

  // low status bits carry density, protection and page size
  status_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_low && sck_fall && st_reg.stat_mode && st_reg.out_bit == `SFB_BIT_LAST
    |=> st_reg.out_byte[5:0] == {`SFB_DENSITY, $past(protect_on), $past(binary_page)})
    else $error("status low bits wrong");

  // deselect must always clear the registered enable
  so_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cs_low
    |=> !st_reg.so_oe)
    else $error("output driven while deselected");
endmodule // sfb_core

// ### verilog/sfb_cfg.svh
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH
`define SFB_OP_XFER1 8'h53
`define SFB_OP_XFER2 8'h55
`define SFB_OP_CMP1 8'h60
`define SFB_OP_CMP2 8'h61
`define SFB_OP_RW1 8'h58
`define SFB_OP_RW2 8'h59
`define SFB_OP_STAT 8'hD7
`define SFB_OP_SLEEP 8'hB9
`define SFB_OP_WAKE 8'hAB
// arbitrary backward-compatible density code, value of our own
`define SFB_DENSITY 4'h5
`define SFB_BIT_LAST 3'h7
`define SFB_CMD_BITS 6'h20
`define SFB_OP_BITS 6'h08
// times in ns, cycles at a 100 ns clock
`define SFB_CLK_NS 100
`define SFB_COPY_NS 200000
`define SFB_MATCH_NS 200000
`define SFB_REWRITE_NS 3000000
`define SFB_SLEEP_NS 3000
`define SFB_WAKE_NS 30000
`define SFB_SLEEP_CYC 16'((`SFB_SLEEP_NS) / (`SFB_CLK_NS))
`define SFB_WAKE_CYC 16'((`SFB_WAKE_NS) / (`SFB_CLK_NS))
`endif

// ### verilog/sfb_pkg.sv
package sfb_pkg;
  typedef enum logic [2:0] {
    SFB_IDLE = 3'h0,
    SFB_BUSY = 3'h1,
    SFB_RW2 = 3'h3,
    SFB_GO_SLEEP = 3'h2,
    SFB_SLEEP = 3'h6,
    SFB_GO_WAKE = 3'h7
  } sfb_mode_t;

  typedef struct packed {
    logic ready;
    logic mismatch;
    logic [3:0] density;
    logic protect;
    logic binary_page;
  } sfb_status_t;

  typedef struct packed {
    logic [2:0] sck_sync;
    logic [1:0] cs_sync;
    logic cs_prev;
    logic [1:0] si_sync;
    logic [5:0] bit_cnt;
    logic [31:0] shift;
    logic stat_mode;
    logic [2:0] out_bit;
    logic [7:0] out_byte;
    logic so_o;
    logic so_oe;
    sfb_mode_t mode;
    logic [21:0] timer;
    logic mismatch;
    logic [10:0] page;
    logic buf_two;
    logic is_cmp;
  } sfb_state_t;
endpackage

// ### tb/sfb_host.sv
module sfb_host (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end
  // mode 0: data changes while the clock is low, reply taken on the rise
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] r);
    r = 8'h00;
    @(negedge mclk) cs_n = 1'h0;
    for (int i = 0; i < n; i++)
    begin
      si = d[31 - i];
      repeat (4) @(negedge mclk);
      sclk = 1'h1;
      r = {r[6:0], so_o};
      repeat (4) @(negedge mclk);
      sclk = 1'h0;
    end
    repeat (4) @(negedge mclk);
    cs_n = 1'h1;
    // released line must not keep its last level
    si = ~si;
    // keep select high long enough for the device to see the rise
    repeat (4) @(negedge mclk);
  endtask
endmodule // sfb_host

// ### tb/tb.sv
`include "sfb_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, cs_n, sclk, si, so_o, so_oe, binary_page, protect_on, page_match;
  logic busy, asleep, page_op_start, buf_two_sel, page_op_is_cmp, mm;
  logic [10:0] page_index, p;
  logic [7:0] r;
  logic [7:0] ops [6] = '{8'h60, 8'h61, 8'h53, 8'h55, 8'h58, 8'h59};
  int fail_count = 0;
  int cmp_count = 0;
  int starts = 0;
  int n;
  sfb_core #(.COPY_CYC(400), .MATCH_CYC(400), .REWRITE_CYC(800)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .binary_page(binary_page),
    .protect_on(protect_on), .page_match(page_match), .busy(busy), .asleep(asleep),
    .page_op_start(page_op_start), .page_index(page_index), .buf_two_sel(buf_two_sel),
    .page_op_is_cmp(page_op_is_cmp));
  // an undriven data line floats high through its pull-up
  sfb_host i_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_oe ? so_o : 1'h1));
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (page_op_start === 1'h1)
      starts <= starts + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic stat(input logic b6);
    i_host.xfer({`SFB_OP_STAT, 24'h000000}, 24, r);
    check(r, {1'h1, b6, `SFB_DENSITY, protect_on, binary_page});
    repeat (5) @(negedge mclk);
    check(so_oe, 1'h0);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'h0 && k < 1000)
    begin
      @(negedge mclk);
      k++;
    end
    check(k < 1000, 1'h1);
  endtask
  initial
  begin
    // budget: six page operations plus sleep and wake, with margin
    repeat (40000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    rst_n = 1'h0;
    binary_page = 1'h0;
    protect_on = 1'h0;
    page_match = 1'h0;
    mm = 1'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'h1;
    repeat (3) @(negedge mclk);
    check(asleep, 1'h0);
    check(busy, 1'h0);
    for (int i = 0; i < 6; i++)
    begin
      binary_page = i[1];
      protect_on = i[0];
      page_match = i[0];
      p = i[0] ? 11'h7FF : 11'h401;
      n = starts;
      i_host.xfer({ops[i], binary_page ? {5'h1F, p, 8'hFF} : {4'hF, p, 9'h1FF}}, 32, r);
      repeat (8) @(negedge mclk);
      check(starts, n + 1);
      check(page_index, p);
      check(buf_two_sel, i[0]);
      check(page_op_is_cmp, i < 2);
      i_host.xfer({`SFB_OP_STAT, 24'h000000}, 16, r);
      check(r[7], 1'h0);
      if (i >= 4)
      begin
        repeat (300) @(negedge mclk);
        check(busy, 1'h1);
      end
      wait_idle();
      if (i < 2)
        mm = ~page_match;
      stat(mm);
    end
    n = starts;
    i_host.xfer({8'h53, 24'h000000}, 31, r);
    repeat (8) @(negedge mclk);
    check(starts, n);
    i_host.xfer({`SFB_OP_SLEEP, 24'h000000}, 8, r);
    repeat (40) @(negedge mclk);
    check(asleep, 1'h1);
    i_host.xfer({8'h53, 24'h000000}, 32, r);
    repeat (8) @(negedge mclk);
    check(starts, n);
    check(busy, 1'h1);
    check(asleep, 1'h1);
    i_host.xfer({`SFB_OP_WAKE, 24'h000000}, 8, r);
    // chip select stays high for the whole wake time
    repeat (310) @(negedge mclk);
    check(asleep, 1'h0);
    stat(mm);
    give_verdict();
  end
endmodule // tb
